// ===== hw/arp_pkg.sv
// Shared types and constants of the record path control block.
// Assumes an 8-bit register port and 16-bit signed samples.
`default_nettype none

package arp_pkg;
	typedef logic [7:0]         arp_byte_t;
	typedef logic signed [15:0] arp_sample_t;

	// ========================================
	// Register offsets
	localparam arp_byte_t OFF_PM     = 8'h03;
	localparam arp_byte_t OFF_CTL6   = 8'h0e;
	localparam arp_byte_t OFF_CTL7   = 8'h0f;
	localparam arp_byte_t OFF_VOL_L  = 8'h10;
	localparam arp_byte_t OFF_VOL_R  = 8'h11;
	localparam arp_byte_t OFF_LIVE_L = 8'h12;
	localparam arp_byte_t OFF_LIVE_R = 8'h13;

	// ========================================
	// Values after reset
	localparam arp_byte_t RST_PM   = 8'hfc;
	localparam arp_byte_t RST_CTL6 = 8'h30;
	localparam arp_byte_t RST_CTL7 = 8'h30;
	localparam arp_byte_t RST_VOL  = 8'hc0;

	// ========================================
	// Field positions
	localparam int BIT_L_SLEEP = 5;
	localparam int BIT_R_SLEEP = 4;
	localparam int BIT_L_FLIP  = 7;
	localparam int BIT_R_FLIP  = 6;
	localparam int BIT_L_DCB   = 5;
	localparam int BIT_R_DCB   = 4;
	localparam int RATE_LSB    = 6;
	localparam int BIT_GLIDE   = 5;
	localparam int BIT_LINK    = 3;
	localparam int BIT_SILENCE = 2;

	// ========================================
	// Attenuation and ramp
	localparam arp_byte_t  ATTEN_MAX        = 8'hc0;
	localparam arp_byte_t  STEPS_PER_6DB    = 8'h0c;
	localparam logic [4:0] SHIFT_ZERO       = 5'h10;
	localparam logic [4:0] MANT_SHIFT       = 5'h0f;
	localparam logic [15:0] DIV12_MUL       = 16'h00ab;
	localparam int         DIV12_SH         = 11;
	localparam int         HPF_SH           = 8;
	localparam logic [5:0] STEP_FRAMES_BASE = 6'h04;
	// Gain of each half-dB step inside one 6 dB octave, Q15
	localparam logic [16:0] GAIN_TAB [12] = '{
		17'h08000, 17'h078d7, 17'h07215, 17'h06bb3,
		17'h065ad, 17'h05ffd, 17'h05a9e, 17'h0558c,
		17'h050c3, 17'h04c3f, 17'h047fb, 17'h043f4
	};
endpackage : arp_pkg

`default_nettype wire

// ===== hw/arp_chan.sv
// One channel of the record datapath: dc block, sign, attenuation.
// Assumes one-cycle sample strobes on the register clock.
`default_nettype none

module arp_chan (
	input  wire logic                 ref_clk,
	input  wire logic                 reset,
	input  wire logic                 clk_en,
	input  wire logic                 in_valid,
	input  wire arp_pkg::arp_sample_t in_sample,
	input  wire logic                 sleep,
	input  wire logic                 flip,
	input  wire logic                 dc_block_en,
	input  wire arp_pkg::arp_byte_t   atten,
	output var  logic                 out_valid,
	output var  arp_pkg::arp_sample_t out_sample
);
	import arp_pkg::*;

	logic signed [23:0] dc_acc;
	logic signed [16:0] hp;
	arp_sample_t        hp_sat;
	arp_sample_t        dcb;
	arp_sample_t        fl;
	arp_byte_t          code;
	logic [15:0]        qprod;
	logic [4:0]         quo;
	logic [3:0]         rem;
	logic signed [33:0] prod;
	arp_sample_t        scaled;

	// ========================================
	// Datapath
	always_comb begin
		hp = 17'(in_sample) - 17'($signed(dc_acc[23:HPF_SH]));
		hp_sat = (hp[16] != hp[15]) ? {hp[16], {15{~hp[16]}}} : hp[15:0];
		dcb = dc_block_en ? hp_sat : in_sample;
		// Full-scale negative would wrap, so it clips instead
		fl = !flip ? dcb : (dcb == 16'sh8000) ? 16'sh7fff : -dcb;
		code = (atten > ATTEN_MAX) ? ATTEN_MAX : atten;
		// Divide by twelve without a divider
		qprod = 16'(code) * DIV12_MUL;
		quo = 5'(qprod >> DIV12_SH);
		rem = 4'(code - 8'(quo) * STEPS_PER_6DB);
		prod = 34'(fl) * $signed({1'b0, GAIN_TAB[rem]});
		scaled = (quo >= SHIFT_ZERO) ? '0
			: 16'(prod >>> (MANT_SHIFT + quo));
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			dc_acc     <= '0;
			out_valid  <= 1'b0;
			out_sample <= '0;
		end else if (clk_en) begin
			out_valid <= in_valid;
			if (in_valid) begin
				dc_acc     <= dc_acc + 24'(hp);
				out_sample <= sleep ? '0 : scaled;
			end
		end
	end

	// ========================================
	// Checks
	property p_flip_exact;
		@(posedge ref_clk) disable iff (reset)
		in_valid && clk_en && flip && !dc_block_en && !sleep
			&& atten == 8'h00 && in_sample != 16'sh8000
		|=> out_sample == -$past(in_sample);
	endproperty
	a_flip_exact: assert property (p_flip_exact)
		else $error("sign flip not applied");

	property p_bypass_exact;
		@(posedge ref_clk) disable iff (reset)
		in_valid && clk_en && !flip && !dc_block_en && !sleep
			&& atten == 8'h00
		|=> out_sample == $past(in_sample);
	endproperty
	a_bypass_exact: assert property (p_bypass_exact)
		else $error("filter bypass altered the sample");

	property p_full_atten;
		@(posedge ref_clk) disable iff (reset)
		in_valid && clk_en && atten >= ATTEN_MAX |=> out_sample == '0;
	endproperty
	a_full_atten: assert property (p_full_atten)
		else $error("full attenuation left signal");
endmodule : arp_chan

`default_nettype wire

// ===== hw/arp_record_path.sv
// Record path control: registers, volume glide, two channel datapaths
// and the serial sample output toward the host receiver.
// Assumes the host drives bit_clk and frame_clock, and that samples
// arrive on ref_clk at least 32 cycles apart.
//
// Design decision made here: the address-and-strobe port.
`default_nettype none

// How it works
// - Left converter sleeps while its power-down bit is 1; reset sets it.
// - Right converter sleeps while its power-down bit is 1; reset sets it.
// - Power register resets to fc, so both converters start asleep.
// - Bit 7 of control 6 flips the sign of left samples.
// - Bit 6 of control 6 flips the sign of right samples.
// - Bit 5 of control 6 enables the left dc blocker, on at reset.
// - Bit 4 of control 6 enables the right dc blocker, on at reset.
// - Bits 7:6 pick one half-dB step per 4, 8, 16 or 32 frames.
// - Bit 5 of control 7 enables stepwise volume glide, on at reset.
// - Bit 3 of control 7 makes both channels follow left volume.
// - Bit 2 of control 7 silences the serial record data output.
// - Left volume attenuates half a dB per code; reset code is c0.
// - Right volume attenuates half a dB per code; reset code is c0.
// - Processed stereo samples leave serially on the record data pin.
module arp_record_path (
	input  wire logic                 ref_clk,
	input  wire logic                 reset,
	input  wire logic                 clk_en,
	input  wire arp_pkg::arp_byte_t   reg_addr,
	input  wire arp_pkg::arp_byte_t   reg_wdata,
	input  wire logic                 reg_write,
	input  wire logic                 reg_read,
	output var  arp_pkg::arp_byte_t   reg_rdata,
	input  wire logic                 sample_strobe,
	input  wire arp_pkg::arp_sample_t left_sample_in,
	input  wire arp_pkg::arp_sample_t right_sample_in,
	output var  logic                 left_converter_sleep,
	output var  logic                 right_converter_sleep,
	input  wire logic                 bit_clk,
	input  wire logic                 frame_clock,
	output var  logic                 record_serial_out
);
	import arp_pkg::*;

	arp_byte_t   pm;
	arp_byte_t   ctl6;
	arp_byte_t   ctl7;
	arp_byte_t   vol_l;
	arp_byte_t   vol_r;
	arp_byte_t   cur_atten [2];
	arp_byte_t   target [2];
	logic        ch_sleep [2];
	logic        ch_flip [2];
	logic        ch_dcb [2];
	arp_sample_t ch_in [2];
	arp_sample_t ch_out [2];
	logic        ch_valid [2];
	arp_sample_t hold [2];
	logic        xfer_tgl;
	logic        glide;
	logic        linked;
	logic        silence;
	logic [5:0]  interval;
	logic [4:0]  frame_cnt;
	logic        step_now;
	logic [2:0]  frame_sync;
	logic        frame_seen;
	logic        frame_tick;
	logic [2:0]  lrst_sync;
	logic        link_rst;
	logic [2:0]  xfer_sync;
	logic        xfer_seen;
	logic [2:0]  mute_sync;
	logic        mute_lvl;
	arp_sample_t lk_word [2];
	logic        fc_r;
	logic        fc_d;
	logic        fr_edge;
	logic        frame_tgl;
	arp_sample_t shifter;
	arp_sample_t lk_load;

	// ========================================
	// Register port
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			pm    <= RST_PM;
			ctl6  <= RST_CTL6;
			ctl7  <= RST_CTL7;
			vol_l <= RST_VOL;
			vol_r <= RST_VOL;
		end else if (clk_en && reg_write) begin
			case (reg_addr)
				OFF_PM:    pm    <= reg_wdata;
				OFF_CTL6:  ctl6  <= reg_wdata;
				OFF_CTL7:  ctl7  <= reg_wdata;
				OFF_VOL_L: vol_l <= reg_wdata;
				OFF_VOL_R: vol_r <= reg_wdata;
				default: ;
			endcase
		end
	end

	// Read data stands for exactly one cycle, zero otherwise
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			reg_rdata <= '0;
		end else if (clk_en) begin
			reg_rdata <= '0;
			if (reg_read) begin
				case (reg_addr)
					OFF_PM:     reg_rdata <= pm;
					OFF_CTL6:   reg_rdata <= ctl6;
					OFF_CTL7:   reg_rdata <= ctl7;
					OFF_VOL_L:  reg_rdata <= vol_l;
					OFF_VOL_R:  reg_rdata <= vol_r;
					OFF_LIVE_L: reg_rdata <= cur_atten[0];
					OFF_LIVE_R: reg_rdata <= cur_atten[1];
					default:    reg_rdata <= '0;
				endcase
			end
		end
	end

	assign left_converter_sleep  = pm[BIT_L_SLEEP];
	assign right_converter_sleep = pm[BIT_R_SLEEP];

	// ========================================
	// Control decode
	always_comb begin
		glide    = ctl7[BIT_GLIDE];
		linked   = ctl7[BIT_LINK];
		silence  = ctl7[BIT_SILENCE];
		interval = STEP_FRAMES_BASE << ctl7[RATE_LSB +: 2];
		ch_sleep[0] = pm[BIT_L_SLEEP];
		ch_sleep[1] = pm[BIT_R_SLEEP];
		ch_flip[0]  = ctl6[BIT_L_FLIP];
		ch_flip[1]  = ctl6[BIT_R_FLIP];
		ch_dcb[0]   = ctl6[BIT_L_DCB];
		ch_dcb[1]   = ctl6[BIT_R_DCB];
		ch_in[0]    = left_sample_in;
		ch_in[1]    = right_sample_in;
		target[0] = (vol_l > ATTEN_MAX) ? ATTEN_MAX : vol_l;
		target[1] = linked ? target[0]
			: (vol_r > ATTEN_MAX) ? ATTEN_MAX : vol_r;
	end

	// ========================================
	// Frame events from the link side
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			frame_sync <= '0;
			frame_seen <= 1'b0;
		end else if (clk_en) begin
			frame_sync <= {frame_sync[1:0], frame_tgl};
			if (frame_sync[1] == frame_sync[2]) begin
				frame_seen <= frame_sync[2];
			end
		end
	end

	assign frame_tick = (frame_sync[1] == frame_sync[2])
		&& (frame_sync[2] != frame_seen);
	assign step_now = frame_tick && (frame_cnt == 5'(interval - 6'h01));

	// A rate change mid-count only stretches one interval
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			frame_cnt <= '0;
		end else if (clk_en && frame_tick) begin
			frame_cnt <= step_now ? '0 : frame_cnt + 5'h01;
		end
	end

	// ========================================
	// Per-channel glide and datapath
	generate
		for (genvar c = 0; c < 2; c++) begin : g_ch
			always_ff @(posedge ref_clk) begin
				if (reset) begin
					cur_atten[c] <= RST_VOL;
				end else if (clk_en) begin
					if (!glide) begin
						cur_atten[c] <= target[c];
					end else if (step_now && cur_atten[c] < target[c]) begin
						cur_atten[c] <= cur_atten[c] + 8'h01;
					end else if (step_now && cur_atten[c] > target[c]) begin
						cur_atten[c] <= cur_atten[c] - 8'h01;
					end
				end
			end

			arp_chan u_chan (
				.ref_clk     (ref_clk),
				.reset       (reset),
				.clk_en      (clk_en),
				.in_valid    (sample_strobe),
				.in_sample   (ch_in[c]),
				.sleep       (ch_sleep[c]),
				.flip        (ch_flip[c]),
				.dc_block_en (ch_dcb[c]),
				.atten       (cur_atten[c]),
				.out_valid   (ch_valid[c]),
				.out_sample  (ch_out[c])
			);
		end
	endgenerate

	// Words stay put until the next sample, long after the link copy
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			hold[0]  <= '0;
			hold[1]  <= '0;
			xfer_tgl <= 1'b0;
		end else if (clk_en && ch_valid[0]) begin
			hold[0]  <= ch_out[0];
			hold[1]  <= ch_out[1];
			xfer_tgl <= ~xfer_tgl;
		end
	end

	// ========================================
	// Link side, on the host's bit clock
	always_ff @(posedge bit_clk) begin
		lrst_sync <= {lrst_sync[1:0], reset};
		if (lrst_sync[1] == lrst_sync[2]) begin
			link_rst <= lrst_sync[2];
		end
	end

	always_ff @(posedge bit_clk) begin
		if (link_rst) begin
			xfer_sync  <= '0;
			xfer_seen  <= 1'b0;
			mute_sync  <= '0;
			mute_lvl   <= 1'b0;
			lk_word[0] <= '0;
			lk_word[1] <= '0;
		end else begin
			xfer_sync <= {xfer_sync[1:0], xfer_tgl};
			mute_sync <= {mute_sync[1:0], silence};
			if (mute_sync[1] == mute_sync[2]) begin
				mute_lvl <= mute_sync[2];
			end
			if (xfer_sync[1] == xfer_sync[2]
				&& xfer_sync[2] != xfer_seen) begin
				xfer_seen  <= xfer_sync[2];
				lk_word[0] <= hold[0];
				lk_word[1] <= hold[1];
			end
		end
	end

	assign fr_edge = fc_r != fc_d;
	// Silence acts on the link so it holds even without new samples
	assign lk_load = mute_lvl ? '0
		: fc_r ? lk_word[1] : lk_word[0];

	always_ff @(posedge bit_clk) begin
		if (link_rst) begin
			fc_r              <= 1'b0;
			fc_d              <= 1'b0;
			frame_tgl         <= 1'b0;
			shifter           <= '0;
			record_serial_out <= 1'b0;
		end else begin
			fc_r <= frame_clock;
			fc_d <= fc_r;
			if (fr_edge && !fc_r) begin
				frame_tgl <= ~frame_tgl;
			end
			if (fr_edge) begin
				record_serial_out <= lk_load[15];
				shifter           <= {lk_load[14:0], 1'b0};
			end else begin
				record_serial_out <= shifter[15];
				shifter           <= {shifter[14:0], 1'b0};
			end
		end
	end

	// ========================================
	// Checks
	property p_left_sleep;
		@(posedge ref_clk) disable iff (reset)
		clk_en && reg_write && reg_addr == OFF_PM
		|=> left_converter_sleep == $past(reg_wdata[BIT_L_SLEEP]);
	endproperty
	a_left_sleep: assert property (p_left_sleep)
		else $error("left sleep does not follow its bit");

	property p_right_sleep;
		@(posedge ref_clk) disable iff (reset)
		clk_en && reg_write && reg_addr == OFF_PM
		|=> right_converter_sleep == $past(reg_wdata[BIT_R_SLEEP]);
	endproperty
	a_right_sleep: assert property (p_right_sleep)
		else $error("right sleep does not follow its bit");

	property p_reset_asleep;
		@(posedge ref_clk) disable iff (reset)
		$past(reset) |-> pm == RST_PM && left_converter_sleep
			&& right_converter_sleep;
	endproperty
	a_reset_asleep: assert property (p_reset_asleep)
		else $error("converters not asleep after reset");

	property p_glide_hold;
		@(posedge ref_clk) disable iff (reset)
		clk_en && glide && !step_now |=> $stable(cur_atten[0]);
	endproperty
	a_glide_hold: assert property (p_glide_hold)
		else $error("volume moved between ramp steps");

	property p_no_glide;
		@(posedge ref_clk) disable iff (reset)
		clk_en && !glide |=> cur_atten[1] == $past(target[1]);
	endproperty
	a_no_glide: assert property (p_no_glide)
		else $error("volume did not jump with glide off");

	property p_linked;
		@(posedge ref_clk) disable iff (reset)
		clk_en && linked && !glide |=> cur_atten[1] == cur_atten[0];
	endproperty
	a_linked: assert property (p_linked)
		else $error("right volume not following left");

	property p_atten_cap;
		@(posedge ref_clk) disable iff (reset)
		cur_atten[0] <= ATTEN_MAX && cur_atten[1] <= ATTEN_MAX;
	endproperty
	a_atten_cap: assert property (p_atten_cap)
		else $error("live attenuation above full scale");

	property p_silence;
		@(posedge bit_clk) disable iff (link_rst)
		fr_edge && mute_lvl |=> record_serial_out == 1'b0
			&& shifter == '0;
	endproperty
	a_silence: assert property (p_silence)
		else $error("silenced frame carried data");

	property p_serial_msb;
		@(posedge bit_clk) disable iff (link_rst)
		fr_edge |=> record_serial_out == $past(lk_load[15])
			##1 (fr_edge || record_serial_out == $past(lk_load[14], 2));
	endproperty
	a_serial_msb: assert property (p_serial_msb)
		else $error("serial word not sent msb first");
endmodule : arp_record_path

`default_nettype wire

// ===== dv/arp_host_rx.sv
// Host receiver model: makes the link clocks and collects serial words.
// Assumes words go out MSB first, launched on the rising bit clock.
`default_nettype none

module arp_host_rx (
	output var logic        bit_clk,
	output var logic        frame_clock,
	input  wire logic       record_serial_out,
	output var logic [15:0] left_word,
	output var logic [15:0] right_word,
	output var logic [31:0] frame_cnt
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam int HALF_BITS = 20;
	int          cnt = 0;
	logic [15:0] shreg = '0;

	// ========================================
	// Clocks
	// Runs through reset: the link side resets on bit clock edges
	initial begin
		bit_clk = 1'b0;
		#3.1;
		forever #7.5 bit_clk = ~bit_clk;
	end
	initial begin
		frame_clock = 1'b0;
		left_word = '0;
		right_word = '0;
		frame_cnt = '0;
	end

	// ========================================
	// Capture
	// Sampled half a bit after launch, far from the changing edge
	always @(negedge bit_clk) begin
		cnt = cnt + 1;
		if (cnt >= 2 && cnt <= 17)
			shreg = {shreg[14:0], record_serial_out};
		if (cnt == HALF_BITS) begin
			if (frame_clock) begin
				right_word = shreg;
				frame_cnt = frame_cnt + 1;
			end else begin
				left_word = shreg;
			end
			frame_clock = ~frame_clock;
			cnt = 0;
		end
	end
endmodule : arp_host_rx

`default_nettype wire

// ===== dv/arp_record_path_tb.sv
// Self-checking bench of the record path control block.
// Assumes the host receiver model drives both link clocks.
`default_nettype none

module arp_record_path_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import arp_pkg::*;

	logic        ref_clk, reset, clk_en, reg_write, reg_read;
	arp_byte_t   reg_addr, reg_wdata, reg_rdata, d, v;
	logic        sample_strobe, bit_clk, frame_clock, record_serial_out;
	arp_sample_t left_sample_in, right_sample_in;
	logic        left_converter_sleep, right_converter_sleep;
	logic [15:0] left_word, right_word;
	logic [31:0] frame_cnt, seed, w;
	int          err_total, n_tests, cyc;
	localparam arp_byte_t OFFS[8] = '{8'h03, 8'h0e, 8'h0f, 8'h10, 8'h11,
		8'h12, 8'h13, 8'h20};
	localparam arp_byte_t RSTV[8] = '{8'hfc, 8'h30, 8'h30, 8'hc0, 8'hc0,
		8'hc0, 8'hc0, 8'h00};

	arp_record_path dut (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata),
		.sample_strobe(sample_strobe), .left_sample_in(left_sample_in),
		.right_sample_in(right_sample_in),
		.left_converter_sleep(left_converter_sleep),
		.right_converter_sleep(right_converter_sleep), .bit_clk(bit_clk),
		.frame_clock(frame_clock), .record_serial_out(record_serial_out));
	arp_host_rx host (.bit_clk(bit_clk), .frame_clock(frame_clock),
		.record_serial_out(record_serial_out), .left_word(left_word),
		.right_word(right_word), .frame_cnt(frame_cnt));

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	// ========================================
	// Helpers
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic logic [15:0] exp_w(arp_sample_t x, logic slp, flp,
			mute, arp_byte_t code);
		arp_sample_t s;
		s = flp ? ((x == 16'sh8000) ? 16'sh7fff : -x) : x;
		if (slp || mute || code >= 8'hc0)
			return 16'h0000;
		return (code == 8'h0c) ? 16'(s >>> 1) : s;
	endfunction : exp_w
	task automatic chk(input logic [15:0] got, exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// Gain steps may round either way by one count
	task automatic chk_near(input logic [15:0] got, exp);
		if (got - exp == 16'h0001 || exp - got == 16'h0001)
			chk(got, got);
		else
			chk(got, exp);
	endtask : chk_near
	task automatic wr(input arp_byte_t a, dat);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= dat;
		reg_write <= 1'b1;
		@(posedge ref_clk);
		reg_write <= 1'b0;
	endtask : wr
	task automatic rd(input arp_byte_t a, output arp_byte_t dat);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge ref_clk);
		reg_read <= 1'b0;
		#1 dat = reg_rdata;
	endtask : rd
	task automatic wait_frames(input int n);
		logic [31:0] f;
		f = frame_cnt;
		while (frame_cnt < f + n)
			@(posedge ref_clk);
	endtask : wait_frames
	// Spacing keeps the crossing to the link side ready
	task automatic send_pair(input arp_sample_t xl, xr);
		@(posedge ref_clk);
		left_sample_in <= xl;
		right_sample_in <= xr;
		sample_strobe <= 1'b1;
		@(posedge ref_clk);
		sample_strobe <= 1'b0;
		repeat (40) @(posedge ref_clk);
	endtask : send_pair
	task automatic run_case(input arp_byte_t pm, c6, c7, vl, vr,
			input arp_sample_t xl, xr);
		wr(OFF_PM, pm);
		wr(OFF_CTL6, c6);
		wr(OFF_CTL7, c7);
		wr(OFF_VOL_L, vl);
		wr(OFF_VOL_R, vr);
		send_pair(xl, xr);
		wait_frames(3);
		chk({15'h0, left_converter_sleep}, {15'h0, pm[5]});
		chk({15'h0, right_converter_sleep}, {15'h0, pm[4]});
		chk_near(left_word, exp_w(xl, pm[5], c6[7], c7[2], vl));
		chk_near(right_word, exp_w(xr, pm[4], c6[6], c7[2],
			c7[3] ? vl : vr));
	endtask : run_case
	task automatic done(input string s);
		$display("test %s done", s);
	endtask : done
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : summarize

	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 90000) begin
			err_total++;
			summarize();
		end
	end

	// ========================================
	// Scenarios
	initial begin
		{reset, clk_en, seed} = {2'b11, 32'h793cd4d3};
		{reg_addr, reg_wdata, reg_write, reg_read} = '0;
		{sample_strobe, left_sample_in, right_sample_in} = '0;
		{err_total, n_tests, cyc} = '0;
		// Long enough for four link clock edges as well
		repeat (16) @(posedge ref_clk);
		reset <= 1'b0;
		chk({left_converter_sleep, right_converter_sleep}, 16'h3);
		for (int i = 0; i < 8; i++) begin
			rd(OFFS[i], d);
			chk(16'(d), 16'(RSTV[i]));
		end
		done("reset");
		for (int i = 0; i < 5; i++) begin
			w = rnd();
			wr(OFFS[i], w[7:0]);
			rd(OFFS[i], d);
			chk(16'(d), 16'(w[7:0]));
		end
		wr(8'h20, 8'h5a);
		rd(8'h20, d);
		chk(16'(d), 16'h0);
		clk_en <= 1'b0;
		wr(OFF_VOL_R, ~w[7:0]);
		clk_en <= 1'b1;
		rd(OFF_VOL_R, d);
		chk(16'(d), 16'(w[7:0]));
		done("registers");
		// Dc blockers off here so words can be predicted exactly
		w = rnd();
		run_case(8'hcc, 8'h00, 8'h00, 8'h00, 8'h00, w[15:0], w[31:16]);
		run_case(8'hcc, 8'hc0, 8'h00, 8'h00, 8'h00, w[31:16], w[15:0]);
		run_case(8'hcc, 8'h80, 8'h00, 8'h00, 8'h00, 16'sh8000, 16'sh8000);
		run_case(8'hcc, 8'h00, 8'h00, 8'h0c, 8'hff, w[15:0], w[31:16]);
		run_case(8'hcc, 8'h00, 8'h08, 8'h00, 8'hc0, w[15:0], w[31:16]);
		run_case(8'hcc, 8'h00, 8'h04, 8'h00, 8'h00, w[15:0], w[31:16]);
		run_case(8'hec, 8'h00, 8'h00, 8'h00, 8'h00, w[15:0], w[31:16]);
		run_case(8'hdc, 8'h00, 8'h00, 8'h00, 8'h00, w[15:0], w[31:16]);
		for (int i = 0; i < 4; i++) begin
			w = rnd();
			// Left code is 00 or 0c, the two gains predicted exactly
			run_case(8'hcc, {w[1:0], 6'h0}, {4'h0, w[2], 3'h0},
				{4'h0, w[3], w[3], 2'h0}, 8'hc0 | w[7:6],
				w[23:8], w[31:16]);
		end
		done("datapath");
		// Leaves dc blockers at their reset setting
		wr(OFF_CTL6, 8'h30);
		// Both channels at full gain so each blocker is really seen
		wr(OFF_CTL7, 8'h00);
		wr(OFF_VOL_L, 8'h00);
		wr(OFF_VOL_R, 8'h00);
		for (int i = 0; i < 600; i++)
			send_pair(16'sh4000, -16'sh4000);
		wait_frames(3);
		chk(16'($signed(left_word) < 16'sh2000), 16'h1);
		chk(16'($signed(right_word) > -16'sh2000), 16'h1);
		done("dc block");
		for (int r = 0; r < 4; r++) begin
			wr(OFF_CTL7, 8'h00);
			wr(OFF_VOL_L, 8'h10);
			rd(OFF_LIVE_L, d);
			chk(16'(d), 16'h10);
			wr(OFF_CTL7, {r[1:0], 6'h20});
			wr(OFF_VOL_L, 8'h00);
			wait_frames(16 << r);
			repeat (60) @(posedge ref_clk);
			rd(OFF_LIVE_L, d);
			chk(16'(d == 8'h0c || d == 8'h0d), 16'h1);
		end
		done("glide");
		summarize();
	end
endmodule : arp_record_path_tb

`default_nettype wire
